// ===== keying_pkg.sv
// shared constants for modem keying and master watchdog
package keying_pkg;
    localparam int unsigned CLK_HZ       = 40000000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;
    localparam logic [15:0] MS_DIV_MAX   = 16'(MS_CYCLES - 1);
    localparam logic [9:0]  S_DIV_MAX    = 10'(MS_PER_S - 1);
    localparam int unsigned ADDR_W       = 4;
    // register word offsets
    localparam logic [3:0]  CTRL_OFS     = 4'h0;
    localparam logic [3:0]  HSK_OFS      = 4'h1;
    localparam logic [3:0]  SEND_OFS     = 4'h2;
    localparam logic [3:0]  SUP_OFS      = 4'h3;
    localparam logic [3:0]  STAT_OFS     = 4'h4;
    localparam logic [3:0]  IRQ_OFS      = 4'h5;
    localparam logic [3:0]  MASK_OFS     = 4'h6;
    localparam logic [3:0]  HEALTH_OFS   = 4'h7;
    // control fields
    localparam int unsigned CTRL_RS485   = 0;
    localparam int unsigned CTRL_HCLR    = 1;
    localparam int unsigned CTRL_SRST    = 2;
    // event fields
    localparam int unsigned EV_FAULT     = 0;
    localparam int unsigned EV_TXGO      = 1;
    localparam int unsigned EV_W         = 2;
    // reset values
    localparam logic [15:0] HSK_RST      = 16'h0000;
    localparam logic [15:0] SEND_RST     = 16'h0000;
    localparam logic [15:0] SUP_RST      = 16'h0000;
    localparam logic [2:0]  CTRL_RST     = 3'h2;
    localparam logic [7:0]  HEALTH_RST   = 8'hff;
    localparam int unsigned HEALTH_W     = 8;
endpackage

// ===== tick_gen.sv
// millisecond and second tick generator
`timescale 1ns/1ps
module tick_gen (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic srst,
    output logic      ms_tick,
    output logic      s_tick
);
    logic [15:0] cyc_q;
    logic [9:0]  ms_q;
    wire         ms_end = (cyc_q == keying_pkg::MS_DIV_MAX);
    wire         s_end  = ms_end && (ms_q == keying_pkg::S_DIV_MAX);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_q <= 16'h0000;
            ms_q  <= 10'h000;
        end else if (ce) begin
            if (srst) begin // see R11
                cyc_q <= 16'h0000;
                ms_q  <= 10'h000;
            end else begin
                cyc_q <= ms_end ? 16'h0000 : cyc_q + 16'h0001;
                if (ms_end)
                    ms_q <= (ms_q == keying_pkg::S_DIV_MAX) ? 10'h000
                                                            : ms_q + 10'h001;
            end
        end
    end
    assign ms_tick = ms_end && !srst; // see R11
    assign s_tick  = s_end && !srst;
endmodule

// ===== tick_down.sv
// loadable down counter stepping on a tick
`timescale 1ns/1ps
module tick_down (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        clr,
    input  wire logic        load,
    input  wire logic [15:0] value,
    input  wire logic        tick,
    output logic             busy,
    output logic             done
);
    logic [15:0] cnt_q;
    logic        run_q;
    wire         last = run_q && tick && (cnt_q == 16'h0001);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 16'h0000;
            run_q <= 1'b0;
        end else if (ce) begin
            if (clr) begin
                run_q <= 1'b0;
            end else if (load) begin
                cnt_q <= value;
                run_q <= (value != 16'h0000);
            end else if (run_q && tick) begin
                cnt_q <= cnt_q - 16'h0001;
                if (cnt_q == 16'h0001)
                    run_q <= 1'b0;
            end
        end
    end
    assign busy = run_q;
    assign done = last && !clr && !load;
endmodule

// ===== modem_keying.sv
// modem keying and master supervision with avalon register slave
//
// Overview of operation
// R1 - handshake delay register 0..65535 ms, reset zero, picks release mode.
// R2 - delay zero: raise request-to-send, hold transmit until clear-to-send.
// R3 - delay nonzero: ignore clear-to-send, wait delay ms, then transmit.
// R4 - only in zero-delay mode, clear-to-send starts send delay before data.
// R5 - send delay 0..65535 ms, reset zero; zero adds no wait.
// R6 - supervision period 0..65535 s, reset zero; zero disables supervision.
// R7 - no master message within period: fault, log event, clear health bit.
// R8 - master polls after period; station must acknowledge that check.
// R9 - configured period is presented outward for the master stations.
// R10 - serial port runs rs232 or rs485 by configuration bit.
// R11 - ms and s ticks from clock; sync reset clears counters and drops rts.
`timescale 1ns/1ps
module modem_keying (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        tx_request,
    input  wire logic        cts,
    input  wire logic        master_msg,
    input  wire logic        check_msg,
    input  wire logic [2:0]  partner_sel,
    output logic             rts,
    output logic             tx_enable,
    output logic             check_ack,
    output logic             master_fault,
    output logic             fault_log,
    output logic [7:0]       partner_health_flags,
    output logic [15:0]      sup_period_out,
    output logic             rs485_mode,
    output logic             irq
);
    typedef enum logic [2:0] {
        K_IDLE, K_WAIT_CTS, K_SEND_DLY, K_HSK_DLY, K_TX
    } key_state_e;

    key_state_e  st_q, st_d;
    logic [2:0]  ctrl_q;
    logic [15:0] hsk_q, send_q, sup_q;
    logic [1:0]  ev_q, mask_q;
    logic [7:0]  health_q;
    logic        ack_pend_q;
    logic        rts_q, txen_q, ack_q, fault_q, log_q, irq_q;
    logic [31:0] rdata_q;
    logic [15:0] sup_o_q;

    wire srst   = ctrl_q[keying_pkg::CTRL_SRST];
    wire hclr   = ctrl_q[keying_pkg::CTRL_HCLR];
    wire ms_tick, s_tick;

    // register access decode, one wait state on reads and writes
    wire acc     = avs_read || avs_write;
    wire acc_go  = acc && ack_pend_q;
    wire wr_go   = avs_write && ack_pend_q;
    wire wr_ctrl = wr_go && (avs_address == keying_pkg::CTRL_OFS);
    wire wr_hsk  = wr_go && (avs_address == keying_pkg::HSK_OFS);
    wire wr_send = wr_go && (avs_address == keying_pkg::SEND_OFS);
    wire wr_sup  = wr_go && (avs_address == keying_pkg::SUP_OFS);
    wire wr_irq  = wr_go && (avs_address == keying_pkg::IRQ_OFS);
    wire wr_mask = wr_go && (avs_address == keying_pkg::MASK_OFS);
    wire wr_hlth = wr_go && (avs_address == keying_pkg::HEALTH_OFS);

    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            keying_pkg::CTRL_OFS:   rd_mux = {29'h0, ctrl_q};
            keying_pkg::HSK_OFS:    rd_mux = {16'h0, hsk_q};
            keying_pkg::SEND_OFS:   rd_mux = {16'h0, send_q};
            keying_pkg::SUP_OFS:    rd_mux = {16'h0, sup_q};
            keying_pkg::STAT_OFS:
                rd_mux = {24'h0, 1'b0, fault_q, txen_q, rts_q,
                          1'b0, 3'(st_q)};
            keying_pkg::IRQ_OFS:    rd_mux = {30'h0, ev_q};
            keying_pkg::MASK_OFS:   rd_mux = {30'h0, mask_q};
            keying_pkg::HEALTH_OFS: rd_mux = {24'h0, health_q};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // delay and supervision counters
    wire cts_mode   = (hsk_q == 16'h0000);                  // see R2
    wire start_key  = (st_q == K_IDLE) && tx_request;
    wire hsk_load   = start_key && !cts_mode;               // see R3
    wire cts_rise   = (st_q == K_WAIT_CTS) && cts;          // see R4
    wire send_load  = cts_rise && (send_q != 16'h0000);     // see R5
    wire hsk_busy, hsk_done, snd_busy, snd_done;
    wire sup_on     = (sup_q != 16'h0000);                  // see R6
    wire sup_busy, sup_done;
    wire sup_load   = sup_on && (master_msg || wr_sup ||
                                 (!sup_busy && !fault_q));

    tick_gen u_ticks (
        .clk     (clk),
        .resetn  (resetn),
        .ce      (ce),
        .srst    (srst),
        .ms_tick (ms_tick),
        .s_tick  (s_tick)
    );

    tick_down u_hsk (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .clr    (srst || !tx_request),
        .load   (hsk_load),
        .value  (hsk_q),
        .tick   (ms_tick),
        .busy   (hsk_busy),
        .done   (hsk_done)
    );

    tick_down u_send (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .clr    (srst || !tx_request),
        .load   (send_load),
        .value  (send_q),
        .tick   (ms_tick),
        .busy   (snd_busy),
        .done   (snd_done)
    );

    tick_down u_sup (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .clr    (srst || !sup_on),
        .load   (sup_load),
        .value  (wr_sup ? avs_writedata[15:0] : sup_q),
        .tick   (s_tick),
        .busy   (sup_busy),
        .done   (sup_done)
    );

    // keying sequence
    always_comb begin
        st_d = st_q;
        case (st_q)
            K_IDLE:
                if (tx_request)
                    st_d = cts_mode ? K_WAIT_CTS : K_HSK_DLY;
            K_WAIT_CTS:
                if (!tx_request)
                    st_d = K_IDLE;
                else if (cts)
                    st_d = (send_q != 16'h0000) ? K_SEND_DLY : K_TX;
            K_SEND_DLY:
                if (!tx_request)
                    st_d = K_IDLE;
                else if (snd_done)
                    st_d = K_TX;                            // see R4
            K_HSK_DLY:
                if (!tx_request)
                    st_d = K_IDLE;
                else if (hsk_done)
                    st_d = K_TX;                            // see R3
            K_TX:
                if (!tx_request)
                    st_d = K_IDLE;
            default:
                st_d = K_IDLE;
        endcase
    end

    wire rts_d  = (st_d != K_IDLE);
    wire txen_d = (st_d == K_TX);
    wire fault_set = sup_done && sup_on;                    // see R7
    wire fault_d = sup_on && !master_msg && (fault_q || fault_set);
    wire [1:0] ev_set = {txen_d && !txen_q, fault_set};
    wire [1:0] ev_d = ev_set |
                      (ev_q & ~(wr_irq ? avs_writedata[1:0] : 2'b00));
    wire [7:0] sel_bit = 8'h01 << partner_sel;
    wire [7:0] health_d = (fault_set && hclr) ? (health_q & ~sel_bit) :
                          wr_hlth ? avs_writedata[7:0] :
                          (master_msg ? (health_q | sel_bit) : health_q);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= K_IDLE;
            rts_q      <= 1'b0;
            txen_q     <= 1'b0;
        end else if (ce) begin
            if (srst) begin                                 // see R11
                st_q   <= K_IDLE;
                rts_q  <= 1'b0;
                txen_q <= 1'b0;
            end else begin
                st_q   <= st_d;
                rts_q  <= rts_d;                            // see R2
                txen_q <= txen_d;
            end
        end
    end

    // supervision, health and acknowledge of master checks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_q  <= 1'b0;
            log_q    <= 1'b0;
            ack_q    <= 1'b0;
            health_q <= keying_pkg::HEALTH_RST;
            sup_o_q  <= keying_pkg::SUP_RST;
        end else if (ce) begin
            fault_q  <= fault_d && !srst;                   // see R7
            log_q    <= fault_set && !srst;                 // see R7
            ack_q    <= check_msg && !srst;                 // see R8
            health_q <= health_d;                           // see R7
            sup_o_q  <= sup_q;                              // see R9
        end
    end

    // configuration registers and bus answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q     <= keying_pkg::CTRL_RST;
            hsk_q      <= keying_pkg::HSK_RST;              // see R1
            send_q     <= keying_pkg::SEND_RST;             // see R5
            sup_q      <= keying_pkg::SUP_RST;              // see R6
            mask_q     <= 2'b00;
            ev_q       <= 2'b00;
            irq_q      <= 1'b0;
            ack_pend_q <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else if (ce) begin
            ack_pend_q <= acc && !ack_pend_q;
            if (acc && !ack_pend_q)
                rdata_q <= rd_mux;
            if (wr_ctrl)
                ctrl_q <= avs_writedata[2:0];               // see R10
            if (wr_hsk)
                hsk_q <= avs_writedata[15:0];               // see R1
            if (wr_send)
                send_q <= avs_writedata[15:0];
            if (wr_sup)
                sup_q <= avs_writedata[15:0];
            if (wr_mask)
                mask_q <= avs_writedata[1:0];
            ev_q  <= ev_d;
            irq_q <= |(ev_d & mask_q);
        end
    end

    assign avs_readdata         = rdata_q;
    assign avs_waitrequest      = acc && !acc_go;
    assign rts                  = rts_q;
    assign tx_enable            = txen_q;
    assign check_ack            = ack_q;
    assign master_fault         = fault_q;
    assign fault_log            = log_q;
    assign partner_health_flags = health_q;
    assign sup_period_out       = sup_o_q;
    assign rs485_mode           = ctrl_q[keying_pkg::CTRL_RS485];
    assign irq                  = irq_q;
endmodule

// ===== keying_assertions.sv
// checker for keying and watchdog ports
`timescale 1ns/1ps
module keying_assertions (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       tx_request,
    input wire logic       master_msg,
    input wire logic       check_msg,
    input wire logic [2:0] partner_sel,
    input wire logic       rts,
    input wire logic       tx_enable,
    input wire logic       check_ack,
    input wire logic       fault_log,
    input wire logic [7:0] partner_health_flags,
    input wire logic       irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_wait_first: assert property ($rose(avs_read | avs_write)
        |-> avs_waitrequest) else $error("bus answered too early");
    a_wait_second: assert property ((avs_read | avs_write) && ce
        && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_rts_drop: assert property (!tx_request && ce
        |=> !rts && !tx_enable) else $error("keying not dropped");
    a_txen_rts: assert property (tx_enable |-> rts)
        else $error("transmit without rts");
    a_rts_cause: assert property ($rose(rts) |-> $past(tx_request))
        else $error("rts without request");
    a_ack_next: assert property (check_msg && ce |=> check_ack)
        else $error("check not acknowledged");
    a_ack_cause: assert property (check_ack |-> $past(check_msg))
        else $error("stray acknowledge");
    a_log_pulse: assert property (fault_log |=> !fault_log)
        else $error("fault log not a pulse");
    a_health_set: assert property (master_msg && ce
        |=> partner_health_flags[$past(partner_sel)])
        else $error("health bit not set");
    c_txen: cover property ($rose(tx_enable));
    c_ack: cover property (check_ack);
    c_irq: cover property ($rose(irq));
endmodule
bind modem_keying keying_assertions u_chk (.clk(clk), .resetn(resetn),
    .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .tx_request(tx_request),
    .master_msg(master_msg), .check_msg(check_msg),
    .partner_sel(partner_sel), .rts(rts), .tx_enable(tx_enable),
    .check_ack(check_ack), .fault_log(fault_log),
    .partner_health_flags(partner_health_flags), .irq(irq));

// ===== modem_model.sv
// modem answering rts with cts after a latency
`timescale 1ns/1ps
module modem_model #(
    parameter int LAT = 6
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic rts,
    input  wire logic answer,
    output logic      cts
);
    int cnt_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 0;
            cts <= 1'b0;
        end else if (!rts || !answer) begin
            cnt_q <= 0;
            cts <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
            cts <= (cnt_q >= LAT);
        end
    end
endmodule

// ===== tb_modem_keying.sv
// self-checking bench for modem keying
`timescale 1ns/1ps
module tb_modem_keying;
    logic        clk, resetn, ce, avs_read, avs_write, avs_waitrequest;
    logic        tx_request, cts, master_msg, check_msg, rts, tx_enable;
    logic        check_ack, master_fault, fault_log, rs485_mode, irq, answer;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [2:0]  partner_sel;
    logic [7:0]  partner_health_flags;
    logic [15:0] sup_period_out, lf;
    logic [31:0] m [0:7];
    int          n_errors, num_checks, i;
    modem_keying uut (.clk(clk), .resetn(resetn), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_request(tx_request), .cts(cts), .master_msg(master_msg),
        .check_msg(check_msg), .partner_sel(partner_sel), .rts(rts),
        .tx_enable(tx_enable), .check_ack(check_ack),
        .master_fault(master_fault), .fault_log(fault_log),
        .partner_health_flags(partner_health_flags),
        .sup_period_out(sup_period_out), .rs485_mode(rs485_mode), .irq(irq));
    modem_model #(.LAT(6)) u_modem (.clk(clk), .resetn(resetn), .rts(rts),
        .answer(answer), .cts(cts));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wt(ref logic s, input int n);
        int k;
        for (k = 0; k < n && s !== 1'b1; k++) @(negedge clk);
        if (s !== 1'b1) begin
            n_errors++;
            report_and_stop;
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 10);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            report_and_stop;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (wr && a < 8)
            m[a] = (a == 5) ? m[a] & ~d : d & (a == 0 ? 32'h7 :
                a == 6 ? 32'h3 : 32'hffff);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task settle;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        {avs_read, avs_write, tx_request, master_msg, check_msg} = 5'h00;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        partner_sel = 3'h0;
        ce = 1'b1;
        answer = 1'b1;
        resetn = 1'b0;
        lf = 16'h60cb;
        m = '{0: 32'h2, 7: 32'hff, default: 32'h0};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 8; i++) rd(4'(i), m[i]);
        rd(4'h9, 32'h0);
        chk(partner_health_flags, 32'hff);
        for (i = 1; i < 4; i++) begin
            lf = lfsr(lf);
            bus(1'b1, 4'(i), {lf, lf});
            rd(4'(i), m[i]);
        end
        settle;
        chk(sup_period_out, m[3]);
        bus(1'b1, 4'h9, 32'h5);
        rd(4'h9, 32'h0);
        bus(1'b1, 4'h0, 32'h3);
        settle;
        chk(rs485_mode, 32'h1);
        bus(1'b1, 4'h0, 32'h2);
        for (i = 1; i < 4; i++) bus(1'b1, 4'(i), 32'h0);
        settle;
        chk(rs485_mode, 32'h0);
        chk(sup_period_out, 32'h0);
        @(posedge clk);
        tx_request <= 1'b1;
        wt(rts, 4);
        chk(tx_enable, 32'h0);
        wt(cts, 40);
        chk(tx_enable, 32'h0);
        @(negedge clk);
        chk(tx_enable, 32'h1);
        chk(irq, 32'h0);
        rd(4'h5, 32'h2);
        bus(1'b1, 4'h6, 32'h2);
        settle;
        chk(irq, 32'h1);
        bus(1'b1, 4'h5, 32'h2);
        settle;
        chk(irq, 32'h0);
        bus(1'b1, 4'h7, 32'h0);
        @(posedge clk);
        tx_request <= 1'b0;
        lf = lfsr(lf);
        partner_sel <= lf[2:0];
        check_msg <= 1'b1;
        master_msg <= 1'b1;
        answer <= 1'b0;
        @(posedge clk);
        check_msg <= 1'b0;
        master_msg <= 1'b0;
        @(negedge clk);
        chk(check_ack, 32'h1);
        chk(rts, 32'h0);
        chk(partner_health_flags, 32'h1 << lf[2:0]);
        bus(1'b1, 4'h1, 32'h1);
        @(posedge clk);
        tx_request <= 1'b1;
        wt(tx_enable, 41000);
        chk(cts, 32'h0);
        chk(rts, 32'h1);
        bus(1'b1, 4'h0, 32'h6);
        settle;
        chk({rts, tx_enable}, 32'h0);
        bus(1'b1, 4'h0, 32'h2);
        @(posedge clk);
        tx_request <= 1'b0;
        answer <= 1'b1;
        bus(1'b1, 4'h1, 32'h0);
        bus(1'b1, 4'h2, 32'h1);
        @(posedge clk);
        tx_request <= 1'b1;
        wt(cts, 40);
        @(negedge clk);
        chk(tx_enable, 32'h0);
        wt(tx_enable, 41000);
        chk(rts, 32'h1);
        @(posedge clk);
        tx_request <= 1'b0;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h1, 32'h0);
        rd(4'h2, 32'h0);
        report_and_stop;
    end
endmodule
